// *** hdl/ebr_pkg.sv ***
/*
 * Shared types and constants of the embedded block memory.
 * Assumes one clock domain and a fabric that drives all controls synchronously.
 */
package ebr_pkg;
    localparam int unsigned MEM_BITS  = 9216;
    localparam int unsigned NARROW_CAP = 8192;
    localparam int unsigned MAX_W     = 18;
    localparam int unsigned ADDR_W    = 13;
    localparam int unsigned POS_W     = 14;
    localparam int unsigned CHUNKS    = MEM_BITS / MAX_W;
    localparam int unsigned CHUNK_W   = 9;

    typedef enum logic [2:0] {
        MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL, MODE_ROM, MODE_FIFO
    } ebr_mode_t;

    typedef enum logic [2:0] { W1, W2, W4, W9, W18 } ebr_width_t;

    typedef enum logic [1:0] {
        SRC_ONE_TIME_CONFIG_MEMORY, SRC_CONFIG_FLASH, SRC_USER_FLASH_AREA
    } ebr_src_t;

    typedef struct packed {
        logic              en;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [MAX_W-1:0]  data;
    } ebr_port_t;

    // Data bits per word for a port width setting.
    function automatic logic [4:0] ebr_bits(input ebr_width_t w);
        case (w)
            W1:      return 5'h01;
            W2:      return 5'h02;
            W4:      return 5'h04;
            W9:      return 5'h09;
            default: return 5'h12;
        endcase
    endfunction

    // Usable array bits for a port width: narrow shapes leave the top 1024 bits unused.
    function automatic logic [POS_W-1:0] ebr_cap(input ebr_width_t w);
        return (w == W9 || w == W18) ? POS_W'(MEM_BITS) : POS_W'(NARROW_CAP);
    endfunction
endpackage

// *** hdl/ebr_block.sv ***
/*
 * Embedded block memory: single port, true dual, pseudo dual, ROM and FIFO.
 * Assumes user logic drives all ports synchronously to clk_in.
 */
// What this block does
// - Shapes 8192x1 to 1024x9; 512x18 in PDP/FIFO.
// - Each port has its own width.
// - Bits laid out word by word, LSB first.
// - Contents load at configuration from chosen source.
// - All-zero image uses no user flash.
// - Identical patterns share one initialization image.
// - ROM is preload plus disabled writes.
// - Address and data registered before array access, except FIFO push and pop, which use a_in and b_in directly.
// - Optional output register after the array.
// - FIFO mode keeps global reset always enabled.
// - FIFO strobes act as clock enables.
// - FIFO and read pointer resets are asynchronous.
// - Sync reset without global reset: no restrictions.
`timescale 1ns/1ps
module ebr_block
    import ebr_pkg::*;
#(
    parameter logic [MEM_BITS-1:0] INIT_IMAGE = '0
) (
    // Clock and resets
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              global_set_reset_in,
    input  wire logic              fifo_reset_in,
    input  wire logic              read_pointer_clear_in,
    // Configuration
    input  wire ebr_mode_t         mode_in,
    input  wire ebr_width_t        a_width_in,
    input  wire ebr_width_t        b_width_in,
    input  wire logic              out_reg_en_in,
    input  wire logic              gsr_enable_in,
    input  wire logic              init_req_in,
    input  wire ebr_src_t          init_src_in,
    // Port A (write side in FIFO mode)
    input  wire ebr_port_t         a_in,
    output logic [MAX_W-1:0]       a_rdata_out,
    output logic                   a_rvalid_out,
    // Port B (read_strobe is b_in.en in FIFO mode)
    input  wire ebr_port_t         b_in,
    output logic [MAX_W-1:0]       b_rdata_out,
    output logic                   b_rvalid_out,
    // Status
    output logic                   fifo_full_out,
    output logic                   fifo_empty_out,
    output logic                   init_busy_out,
    output logic                   user_flash_used_out
);
    typedef enum logic { INI_IDLE, INI_LOAD } ebr_ini_t;

    logic              mem_q [MEM_BITS];
    ebr_port_t         a_q, b_q;
    ebr_ini_t          ini_q;
    logic [CHUNK_W-1:0] chunk_q;
    logic [MAX_W-1:0]  rda_q, rdb_q, outa_q, outb_q;
    logic              va1_q, va2_q, vb1_q, vb2_q, uf_q;
    logic [POS_W-1:0]  wpos_q, rpos_q, fill, cap;
    logic              wlap_q, rlap_q;
    logic [4:0]        aw, bw;
    logic              fifo, global_set_reset, wr_a, wr_b, rd_a, rd_b, push, pop;
    logic [POS_W:0]    a_base, b_base;

    assign fifo = (mode_in == MODE_FIFO);
    assign aw   = ebr_bits(a_width_in);
    assign bw   = ebr_bits(b_width_in);
    assign cap  = ebr_cap(a_width_in);
    // global reset forced on in FIFO mode
    // disabled global reset leaves only sync reset
    assign global_set_reset  = global_set_reset_in & (gsr_enable_in | fifo);
    // linear bit address, word times width
    // The product is widened first so addresses above 8191 bits do not wrap.
    assign a_base = (POS_W+1)'(a_q.addr) * (POS_W+1)'(aw);
    assign b_base = (POS_W+1)'(b_q.addr) * (POS_W+1)'(bw);

    // ROM and busy loads block writes
    assign wr_a = a_q.en & a_q.we & ~init_busy_out & ~fifo & (mode_in != MODE_ROM);
    assign wr_b = b_q.en & b_q.we & ~init_busy_out & (mode_in == MODE_TRUE_DUAL);
    assign rd_a = a_q.en & ~a_q.we & (mode_in inside {MODE_SINGLE, MODE_TRUE_DUAL, MODE_ROM});
    assign rd_b = b_q.en & ~b_q.we & (mode_in inside {MODE_TRUE_DUAL, MODE_PSEUDO_DUAL, MODE_ROM});

    assign fill = (wlap_q == rlap_q) ? POS_W'(wpos_q - rpos_q) : POS_W'(cap - rpos_q + wpos_q);
    assign fifo_full_out  = ({1'b0, fill} + (POS_W+1)'(aw)) > {1'b0, cap};
    assign fifo_empty_out = fill < POS_W'(bw);
    assign push = fifo & a_in.we & ~fifo_full_out & ~init_busy_out;
    assign pop  = fifo & b_in.en & ~fifo_empty_out;

    assign init_busy_out       = (ini_q == INI_LOAD);
    assign user_flash_used_out = uf_q;

    function automatic logic [MAX_W-1:0] rd_word(input logic [POS_W:0] base,
                                                 input logic [4:0] w);
        logic [MAX_W-1:0] v;
        v = '0;
        for (int i = 0; i < MAX_W; i++) begin
            if (i < w && (int'(base) + i) < MEM_BITS) begin
                v[i] = mem_q[int'(base) + i];
            end
        end
        return v;
    endfunction

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            a_q <= '0;
            b_q <= '0;
        end else begin
            a_q <= a_in;
            b_q <= b_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ini_q   <= INI_IDLE;
            chunk_q <= '0;
            uf_q    <= 1'b0;
        end else begin
            case (ini_q)
                INI_IDLE: begin
                    if (init_req_in) begin
                        ini_q   <= INI_LOAD;
                        chunk_q <= '0;
                        // zero image costs no user flash
                        uf_q    <= (init_src_in == SRC_USER_FLASH_AREA) && (|INIT_IMAGE);
                    end
                end
                default: begin
                    if (chunk_q == CHUNK_W'(CHUNKS - 1)) begin
                        ini_q <= INI_IDLE;
                    end
                    chunk_q <= chunk_q + 1'b1;
                end
            endcase
        end
    end

    // Array writes; on a same-bit collision the later assignment in loop order wins: port B at equal bit index i, else the port with higher i.
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < MAX_W; i++) begin
            if (init_busy_out) begin
                // one shared image parameter feeds every block
                mem_q[int'(chunk_q) * MAX_W + i] <= INIT_IMAGE[int'(chunk_q) * MAX_W + i];
            end else begin
                if (wr_a && i < aw && (int'(a_base) + i) < int'(ebr_cap(a_width_in))) begin
                    mem_q[int'(a_base) + i] <= a_q.data[i];
                end
                if (wr_b && i < bw && (int'(b_base) + i) < int'(ebr_cap(b_width_in))) begin
                    mem_q[int'(b_base) + i] <= b_q.data[i];
                end
                if (push && i < aw) begin
                    mem_q[int'(wpos_q) + i] <= a_in.data[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge fifo_reset_in) begin
        if (fifo_reset_in) begin
            wpos_q <= '0;
            wlap_q <= 1'b0;
        end else if (reset_in || global_set_reset) begin
            wpos_q <= '0;
            wlap_q <= 1'b0;
        end else if (push) begin
            if (POS_W'(wpos_q + aw) >= cap) begin
                wpos_q <= POS_W'(wpos_q + aw - cap);
                wlap_q <= ~wlap_q;
            end else begin
                wpos_q <= POS_W'(wpos_q + aw);
            end
        end
    end

    always_ff @(posedge clk_in or posedge fifo_reset_in or posedge read_pointer_clear_in) begin
        if (fifo_reset_in || read_pointer_clear_in) begin
            rpos_q <= '0;
            rlap_q <= 1'b0;
        end else if (reset_in || global_set_reset) begin
            rpos_q <= '0;
            rlap_q <= 1'b0;
        end else if (pop) begin
            if (POS_W'(rpos_q + bw) >= cap) begin
                rpos_q <= POS_W'(rpos_q + bw - cap);
                rlap_q <= ~rlap_q;
            end else begin
                rpos_q <= POS_W'(rpos_q + bw);
            end
        end
    end

    // array output one edge after address
    always_ff @(posedge clk_in) begin
        if (reset_in || global_set_reset) begin
            rda_q <= '0;
            rdb_q <= '0;
            va1_q <= 1'b0;
            vb1_q <= 1'b0;
        end else begin
            va1_q <= rd_a;
            vb1_q <= rd_b | pop;
            if (rd_a) begin
                rda_q <= rd_word(a_base, aw);
            end
            if (pop) begin
                rdb_q <= rd_word({1'b0, rpos_q}, bw);
            end else if (rd_b) begin
                rdb_q <= rd_word(b_base, bw);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || global_set_reset) begin
            outa_q <= '0;
            outb_q <= '0;
            va2_q  <= 1'b0;
            vb2_q  <= 1'b0;
        end else begin
            outa_q <= rda_q;
            outb_q <= rdb_q;
            va2_q  <= va1_q;
            vb2_q  <= vb1_q;
        end
    end

    assign a_rdata_out  = out_reg_en_in ? outa_q : rda_q;
    assign b_rdata_out  = out_reg_en_in ? outb_q : rdb_q;
    assign a_rvalid_out = out_reg_en_in ? va2_q : va1_q;
    assign b_rvalid_out = out_reg_en_in ? vb2_q : vb1_q;

    property p_in_reg;
        @(posedge clk_in) disable iff (reset_in) a_in.en |=> a_q.addr == $past(a_in.addr);
    endproperty
    a_in_reg: assert property (p_in_reg) else $error("port A address not registered");

    property p_lat_direct;
        @(posedge clk_in) disable iff (reset_in || global_set_reset)
            (a_in.en && !a_in.we && mode_in == MODE_SINGLE && !out_reg_en_in)
            ##1 !out_reg_en_in |=> a_rvalid_out;
    endproperty
    a_lat_direct: assert property (p_lat_direct) else $error("read latency wrong");

    property p_lat_reg;
        @(posedge clk_in) disable iff (reset_in || global_set_reset)
            (a_in.en && !a_in.we && mode_in == MODE_SINGLE && out_reg_en_in)
            ##1 out_reg_en_in[*2] |=> a_rvalid_out;
    endproperty
    a_lat_reg: assert property (p_lat_reg) else $error("registered latency wrong");

    property p_rom;
        @(posedge clk_in) disable iff (reset_in) mode_in == MODE_ROM |-> !wr_a && !wr_b;
    endproperty
    a_rom: assert property (p_rom) else $error("write in ROM mode");

    property p_full;
        @(posedge clk_in) disable iff (reset_in || global_set_reset || fifo_reset_in)
            fifo && fifo_full_out && a_in.we |=> $stable(wpos_q) && $stable(wlap_q);
    endproperty
    a_full: assert property (p_full) else $error("write accepted while full");

    property p_empty;
        @(posedge clk_in) disable iff (reset_in || global_set_reset || fifo_reset_in || read_pointer_clear_in)
            fifo && fifo_empty_out && b_in.en |=> $stable(rpos_q);
    endproperty
    a_empty: assert property (p_empty) else $error("read accepted while empty");

    property p_strobe;
        @(posedge clk_in) disable iff (reset_in || global_set_reset || fifo_reset_in)
            fifo && !a_in.we |=> $stable(wpos_q);
    endproperty
    a_strobe: assert property (p_strobe) else $error("write without strobe");

    property p_rp_clear;
        @(posedge clk_in) disable iff (reset_in) read_pointer_clear_in |-> rpos_q == '0;
    endproperty
    a_rp_clear: assert property (p_rp_clear) else $error("read pointer not cleared");

    property p_gsr_fifo;
        @(posedge clk_in) disable iff (reset_in)
            fifo && global_set_reset_in |=> wpos_q == '0 && !b_rvalid_out;
    endproperty
    a_gsr_fifo: assert property (p_gsr_fifo) else $error("global reset ignored in FIFO");

    c_write_read: cover property (@(posedge clk_in) wr_a ##1 rd_a);
    c_fifo_full:  cover property (@(posedge clk_in) fifo && fifo_full_out);
    c_init:       cover property (@(posedge clk_in) init_busy_out ##1 !init_busy_out);
endmodule

// *** tb/ebr_fabric_model.sv ***
/*
 * Fabric-side user logic that forms the two port requests of the block.
 * Assumes the bench changes the requests at the falling clock edge.
 */
`timescale 1ns/1ps
module ebr_fabric_model
    import ebr_pkg::*;
(
    // Controls
    input  wire logic      rst_any_in,
    input  wire logic      rom_mode_in,
    input  wire logic      bad_write_in,
    // Requests from the scenario
    input  wire ebr_port_t a_req_in,
    input  wire ebr_port_t b_req_in,
    // Ports toward the block
    output ebr_port_t      a_port_out,
    output ebr_port_t      b_port_out
);
    always_comb begin
        a_port_out = a_req_in;
        b_port_out = b_req_in;
        if (rom_mode_in && !bad_write_in) begin
            a_port_out.we = 1'b0;
            b_port_out.we = 1'b0;
        end
        if (rst_any_in) begin
            a_port_out = '0;
            b_port_out = '0;
        end
    end
endmodule

// *** tb/ebr_block_tb_top.sv ***
/*
 * Self-checking bench of the embedded block memory.
 * Assumes the package, the block and the fabric model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module ebr_block_tb_top
    import ebr_pkg::*;
;
    int               bad_count;
    int               n_compared;
    logic             clk_in, reset_in, global_set_reset, gsr_en, fifo_rst, rpc, oreg, init_req, bad_wr;
    ebr_mode_t        mode;
    ebr_width_t       aw, bw;
    ebr_src_t         src;
    ebr_port_t        ra, rb, a_in, b_in;
    logic [MAX_W-1:0] a_rd, b_rd;
    logic             a_v, b_v, full, empty, busy, user_flash_area;

    ebr_fabric_model i_ebr_fabric_model (
        .rst_any_in(reset_in | global_set_reset | fifo_rst | rpc), .rom_mode_in(mode == MODE_ROM),
        .bad_write_in(bad_wr), .a_req_in(ra), .b_req_in(rb),
        .a_port_out(a_in), .b_port_out(b_in));

    ebr_block i_ebr_block (
        .clk_in(clk_in), .reset_in(reset_in), .global_set_reset_in(global_set_reset),
        .fifo_reset_in(fifo_rst), .read_pointer_clear_in(rpc), .mode_in(mode),
        .a_width_in(aw), .b_width_in(bw), .out_reg_en_in(oreg), .gsr_enable_in(gsr_en),
        .init_req_in(init_req), .init_src_in(src), .a_in(a_in), .a_rdata_out(a_rd),
        .a_rvalid_out(a_v), .b_in(b_in), .b_rdata_out(b_rd), .b_rvalid_out(b_v),
        .fifo_full_out(full), .fifo_empty_out(empty), .init_busy_out(busy),
        .user_flash_used_out(user_flash_area));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cfg(ebr_mode_t m, ebr_width_t wa, ebr_width_t wb, logic o);
        mode = m;
        aw = wa;
        bw = wb;
        oreg = o;
        reset_in = 1'b1;
        @(negedge clk_in);
        reset_in = 1'b0;
    endtask

    task automatic wr(bit pb, int ad, logic [MAX_W-1:0] d);
        ebr_port_t r;
        r = '{en: 1'b1, we: 1'b1, addr: ADDR_W'(ad), data: d};
        rb = pb ? r : rb;
        ra = pb ? ra : r;
        @(negedge clk_in);
        ra = '0;
        rb = '0;
        @(negedge clk_in);
    endtask

    // Reads one word and checks it lat falling edges after the request.
    task automatic rd(bit pb, int ad, int lat, logic [MAX_W-1:0] e, logic [MAX_W-1:0] m);
        ebr_port_t r;
        r = '{en: 1'b1, we: 1'b0, addr: ADDR_W'(ad), data: '0};
        rb = pb ? r : rb;
        ra = pb ? ra : r;
        @(negedge clk_in);
        ra = '0;
        rb = '0;
        repeat (lat - 1) @(negedge clk_in);
        `CHK(pb ? b_v : a_v, 1'b1)
        `CHK((pb ? b_rd : a_rd) & m, e)
        @(negedge clk_in);
    endtask

    task automatic s_rom();
        cfg(MODE_ROM, W9, W9, 1'b0);
        src = SRC_USER_FLASH_AREA;
        init_req = 1'b1;
        @(negedge clk_in);
        init_req = 1'b0;
        @(negedge clk_in);
        `CHK(busy, 1'b1)
        repeat (513) @(negedge clk_in);
        `CHK(busy, 1'b0)
        `CHK(user_flash_area, 1'b0)
        bad_wr = 1'b1;
        wr(0, 2, 18'h1ff);
        bad_wr = 1'b0;
        rd(0, 2, 2, 18'h0, 18'h1ff);
    endtask

    task automatic s_dual(logic o);
        cfg(MODE_TRUE_DUAL, W9, W4, o);
        wr(0, 3, 18'h1a5);
        rd(1, 7, o ? 3 : 2, (18'h1a5 >> 1) & 18'hf, 18'hf);
        wr(1, 9, 18'h3);
        rd(0, 4, o ? 3 : 2, 18'h3, 18'h1ff);
    endtask

    task automatic s_mixed();
        cfg(MODE_PSEUDO_DUAL, W18, W9, 1'b0);
        wr(0, 511, 18'h2a5c3);
        rd(1, 1022, 2, 18'h2a5c3 & 18'h1ff, 18'h1ff);
        rd(1, 1023, 2, 18'h2a5c3 >> 9, 18'h1ff);
    endtask

    task automatic s_fifo();
        cfg(MODE_FIFO, W9, W9, 1'b0);
        rb.en = 1'b1;
        @(negedge clk_in);
        rb = '0;
        @(negedge clk_in);
        `CHK(b_v, 1'b0)
        for (int i = 0; i < 1025; i++) begin
            ra = '{en: 1'b1, we: 1'b1, addr: '0, data: MAX_W'(i % 512)};
            @(negedge clk_in);
        end
        ra = '0;
        `CHK(full, 1'b1)
        for (int i = 0; i < 1024; i++) begin
            rd(1, 0, 1, MAX_W'(i % 512), 18'h1ff);
        end
        `CHK(empty, 1'b1)
    endtask

    task automatic s_fifo_rst();
        repeat (3) wr(0, 0, 18'h7);
        #10 fifo_rst = 1'b1;
        #1 `CHK(empty, 1'b1)
        @(negedge clk_in);
        fifo_rst = 1'b0;
        wr(0, 0, 18'h5);
        wr(0, 0, 18'h6);
        rd(1, 0, 1, 18'h5, 18'h1ff);
        rd(1, 0, 1, 18'h6, 18'h1ff);
        #10 rpc = 1'b1;
        #1 `CHK(empty, 1'b0)
        @(negedge clk_in);
        rpc = 1'b0;
        global_set_reset = 1'b1;
        @(negedge clk_in);
        global_set_reset = 1'b0;
        `CHK(empty, 1'b1)
    endtask

    initial begin
        bad_count = 0;
        n_compared = 0;
        reset_in = 1'b1;
        global_set_reset = 1'b0;
        gsr_en = 1'b0;
        {fifo_rst, rpc, oreg, init_req, bad_wr} = '0;
        {mode, aw, bw, src} = '0;
        ra = '0;
        rb = '0;
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        s_rom();
        s_dual(1'b0);
        s_dual(1'b1);
        s_mixed();
        s_fifo();
        s_fifo_rst();
        tally_and_finish();
    end

    // The scenarios need about 4000 cycles; five times that cuts a hang.
    initial begin
        #(50 * 20000);
        bad_count++;
        tally_and_finish();
    end
endmodule
